// File: test/asfr_chk.sv
`timescale 1ns/100ps
`default_nettype none
// ====================
// Port checker
module asfr_chk
  import asfr_pkg::*;
#(
  parameter int unsigned SWITCH_CYC = ASFR_SWITCH_CYC
) (
  // Clock and reset
  input wire logic                   ref_clk,
  input wire logic                   rst_b,
  // Request
  input wire asfr_op_t               op,
  input wire asfr_mem_t              mem_kind,
  input wire logic [ASFR_ADDR_W-1:0] mem_addr,
  // Answer
  input wire logic                   busy,
  input wire logic                   done,
  input wire logic                   ovf_exc,
  input wire logic                   align_exc,
  input wire logic                   line_split,
  input wire logic [ASFR_NREGS-1:0]  tag_valid,
  input wire logic [ASFR_IDX_W-1:0]  stack_top
);
  localparam int WMAX = SWITCH_CYC + 1;
  logic go, pk, wf, mis8;
  assign go = (op != ASFR_OP_NONE) && !busy;
  assign pk = go && (op == ASFR_OP_PK_WR || op == ASFR_OP_PK_RD);
  assign wf = (mem_kind == ASFR_MEM_WIDE) && (mem_addr[3:0] != 4'h0);
  assign mis8 = mem_addr[2:0] != 3'h0;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  exc_with_done_a: assert property ((ovf_exc || align_exc || line_split) |-> done)
    else $error("exception without done");
  pk_sets_tags_a: assert property (pk && !wf |=> tag_valid == ASFR_TAG_ALL)
    else $error("tags not all set");
  empty_clears_a: assert property (go && op == ASFR_OP_EMPTY |=> tag_valid == ASFR_TAG_NONE)
    else $error("tags not cleared");
  wide_fault_a: assert property (pk && wf |=> align_exc && $stable(tag_valid))
    else $error("wide fault wrong");
  unaligned_move_a: assert property (pk && mem_kind == ASFR_MEM_WIDE_UNALIGNED |=> done && !align_exc)
    else $error("unaligned move faulted");
  narrow_split_a: assert property (pk && mem_kind == ASFR_MEM_NARROW |=>
    done && !align_exc && line_split == $past(mis8))
    else $error("narrow access wrong");
  ovf_no_write_a: assert property (ovf_exc |-> $stable(stack_top) && $stable(tag_valid))
    else $error("overflow changed state");
  push_slot_a: assert property (done && !ovf_exc && $past(op) == ASFR_OP_FP_PUSH |->
    tag_valid[stack_top] && stack_top == $past(stack_top) - 3'h1)
    else $error("push slot wrong");
  switch_bound_a: assert property (busy |-> ##[1:WMAX] !busy)
    else $error("switch wait too long");
  cover property (ovf_exc);
  cover property (align_exc);
  cover property (line_split);
  cover property (busy ##1 !busy);
endmodule
bind asfr_regfile asfr_chk #(.SWITCH_CYC(SWITCH_CYC)) i_asfr_chk (.ref_clk, .rst_b, .op,
  .mem_kind, .mem_addr, .busy, .done, .ovf_exc, .align_exc, .line_split, .tag_valid, .stack_top);
`default_nettype wire

// File: test/asfr_pipe.sv
`timescale 1ns/100ps
`default_nettype none
// ====================
// Pipeline side
module asfr_pipe
  import asfr_pkg::*;
(
  // Clock
  input  wire logic       ref_clk,
  // Request
  output var asfr_op_t    op,
  output var logic [2:0]  reg_idx,
  output var logic [79:0] wr_data,
  output var asfr_mem_t   mem_kind,
  output var logic [31:0] mem_addr
);
  initial begin
    op = ASFR_OP_NONE;
    reg_idx = 3'h0;
    wr_data = 80'h0;
    mem_kind = ASFR_MEM_NONE;
    mem_addr = 32'h0;
  end
  // Held n edges: a re-taken op would execute twice
  task automatic issue(input asfr_op_t o, input logic [2:0] i, input logic [79:0] d,
                       input asfr_mem_t k, input logic [31:0] a, input int n);
    op <= o;
    reg_idx <= i;
    wr_data <= d;
    mem_kind <= k;
    mem_addr <= a;
    repeat (n) @(posedge ref_clk);
    op <= ASFR_OP_NONE;
  endtask
endmodule
`default_nettype wire

// File: test/tb.sv
`timescale 1ns/100ps
`default_nettype none
// ====================
// Bench
module tb;
  import asfr_pkg::*;
  localparam int SW = 3;
  logic ref_clk, rst_b, busy, done, ovf_exc, align_exc, line_split, m_pk;
  asfr_op_t op;
  asfr_mem_t mem_kind;
  logic [2:0] reg_idx, stack_top, m_top;
  logic [79:0] wr_data, rd_data, m_rd;
  logic [79:0] m_reg [8];
  logic [31:0] mem_addr;
  logic [7:0] tag_valid, m_tag;
  logic [15:0] lf;
  int failures, comparisons, cyc;
  asfr_regfile #(.SWITCH_CYC(SW)) i_asfr_regfile (.ref_clk, .rst_b, .op, .reg_idx, .wr_data,
    .mem_kind, .mem_addr, .busy, .done, .rd_data, .tag_valid, .stack_top, .ovf_exc,
    .align_exc, .line_split);
  asfr_pipe i_asfr_pipe (.ref_clk, .op, .reg_idx, .wr_data, .mem_kind, .mem_addr);
  function automatic logic [15:0] nx(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  task automatic final_report();
    $display("failures=%0d comparisons=%0d", failures, comparisons);
    if (failures == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic [79:0] s, input logic [79:0] e);
    comparisons++;
    if (s !== e) begin
      failures++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic req(input asfr_op_t o, input logic [2:0] i, input asfr_mem_t k,
                     input logic [31:0] a);
    logic [79:0] d;
    logic fa, sp, ov, pk;
    logic [2:0] s;
    int w;
    lf = nx(lf);
    d = {lf, {4{lf}}};
    pk = (o == ASFR_OP_PK_WR || o == ASFR_OP_PK_RD);
    fa = pk && (k == ASFR_MEM_WIDE) && (a[3:0] != 4'h0);
    sp = pk && (((k == ASFR_MEM_NARROW) && (a[2:0] != 3'h0)) ||
                ((k == ASFR_MEM_WIDE_UNALIGNED) && (a[3:0] != 4'h0)));
    ov = 1'b0;
    s = m_top - 3'h1;
    w = 0;
    @(posedge ref_clk);
    i_asfr_pipe.issue(o, i, d, k, a, (o >= ASFR_OP_FP_PUSH && m_pk) ? SW + 1 : 1);
    #1;
    while (done !== 1'b1 && w < 8) begin
      @(posedge ref_clk);
      #1;
      w++;
    end
    if (!fa) begin
      case (o)
        ASFR_OP_PK_WR: m_reg[i] = {16'hFFFF, d[63:0]};
        ASFR_OP_PK_RD: m_rd = {16'h0000, m_reg[i][63:0]};
        ASFR_OP_EMPTY: m_tag = 8'h00;
        ASFR_OP_FP_RD: m_rd = m_reg[m_top + i];
        ASFR_OP_FP_WR: m_reg[m_top + i] = d;
        ASFR_OP_FP_PUSH: ov = m_tag[s];
        default: ;
      endcase
      if (o == ASFR_OP_FP_PUSH && !ov) begin
        m_reg[s] = d;
        m_tag[s] = 1'b1;
        m_top = s;
      end
      if (pk) m_tag = 8'hFF;
      if (o != ASFR_OP_EMPTY) m_pk = pk;
    end
    chk(done, 1'b1);
    chk(ovf_exc, ov);
    chk(align_exc, fa);
    chk(line_split, sp);
    chk(tag_valid, m_tag);
    chk(stack_top, m_top);
    chk(rd_data, m_rd);
  endtask
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      failures++;
      final_report();
    end
  end
  initial begin
    rst_b = 1'b0;
    {m_tag, m_top, m_rd, m_pk, failures, comparisons, cyc} = '0;
    lf = 16'hB14D;
    foreach (m_reg[j]) m_reg[j] = 80'h0;
    repeat (4) @(posedge ref_clk);
    rst_b <= 1'b1;
    #1;
    chk(tag_valid, 8'h00);
    for (int i = 0; i < 8; i++) req(ASFR_OP_PK_WR, i[2:0], ASFR_MEM_NONE, 32'h0);
    for (int i = 0; i < 8; i++) req(ASFR_OP_FP_RD, i[2:0], ASFR_MEM_NONE, 32'h0);
    req(ASFR_OP_PK_RD, 3'h5, ASFR_MEM_NONE, 32'h0);
    req(ASFR_OP_FP_PUSH, 3'h0, ASFR_MEM_NONE, 32'h0);
    req(ASFR_OP_EMPTY, 3'h0, ASFR_MEM_NONE, 32'h0);
    for (int i = 0; i < 9; i++) req(ASFR_OP_FP_PUSH, 3'h0, ASFR_MEM_NONE, 32'h0);
    for (int i = 0; i < 8; i++) req(ASFR_OP_PK_RD, i[2:0], ASFR_MEM_NONE, 32'h0);
    req(ASFR_OP_FP_WR, 3'h2, ASFR_MEM_NONE, 32'h0);
    req(ASFR_OP_FP_RD, 3'h2, ASFR_MEM_NONE, 32'h0);
    for (int i = 0; i < 24; i++) begin
      req(ASFR_OP_EMPTY, 3'h0, ASFR_MEM_NONE, 32'h0);
      req(ASFR_OP_PK_RD, i[2:0], asfr_mem_t'(lf[1:0]), {16'h0, lf});
    end
    final_report();
  end
endmodule
`default_nettype wire

// File: verilog/asfr_align_chk.sv
`timescale 1ns/100ps
`default_nettype none
module asfr_align_chk
  import asfr_pkg::*;
(
  asfr_align_if.chk m
);
  // ==========================================================
  // Alignment check
  always_comb begin
    m.fault = 1'b0;
    m.split = 1'b0;
    case (m.kind)
      ASFR_MEM_WIDE: begin
        m.fault = |(m.addr[3:0] & ASFR_WIDE_ALIGN);
      end
      ASFR_MEM_WIDE_UNALIGNED: begin
        m.split = |(m.addr[3:0] & ASFR_WIDE_ALIGN);
      end
      ASFR_MEM_NARROW: begin
        // Never faults, only costs a second line
        m.split = |(m.addr[2:0] & ASFR_NARW_ALIGN);
      end
      default: begin
        m.fault = 1'b0;
      end
    endcase
  end
endmodule
`default_nettype wire

// File: verilog/asfr_align_if.sv
`timescale 1ns/100ps
`default_nettype none
interface asfr_align_if;
  import asfr_pkg::*;
  asfr_mem_t              kind;
  logic [ASFR_ADDR_W-1:0] addr;
  logic                   fault;
  logic                   split;
  modport chk (input kind, addr, output fault, split);
  modport top (output kind, addr, input fault, split);
endinterface
`default_nettype wire

// File: verilog/asfr_pkg.sv
package asfr_pkg;
  // ==========================================================
  // Geometry
  localparam int unsigned ASFR_NREGS      = 8;
  localparam int unsigned ASFR_IDX_W      = 3;
  localparam int unsigned ASFR_PK_W       = 64;
  localparam int unsigned ASFR_FP_W       = 80;
  localparam int unsigned ASFR_ADDR_W     = 32;
  // ==========================================================
  // Alignment masks (low address bits that must be zero)
  localparam logic [3:0]  ASFR_WIDE_ALIGN = 4'hF;
  localparam logic [2:0]  ASFR_NARW_ALIGN = 3'h7;
  // ==========================================================
  // Timing, tag patterns and exponent fill
  localparam int unsigned ASFR_SWITCH_CYC = 2;
  localparam logic [7:0]  ASFR_TAG_ALL    = 8'hFF;
  localparam logic [7:0]  ASFR_TAG_NONE   = 8'h00;
  localparam logic [15:0] ASFR_EXP_ONES   = 16'hFFFF;

  // ==========================================================
  // Operations issued by the pipeline
  typedef enum logic [2:0] {
    ASFR_OP_NONE,
    ASFR_OP_PK_WR,
    ASFR_OP_PK_RD,
    ASFR_OP_EMPTY,
    ASFR_OP_FP_PUSH,
    ASFR_OP_FP_WR,
    ASFR_OP_FP_RD
  } asfr_op_t;

  typedef enum logic [1:0] {
    ASFR_MEM_NONE,
    ASFR_MEM_NARROW,
    ASFR_MEM_WIDE,
    ASFR_MEM_WIDE_UNALIGNED
  } asfr_mem_t;
endpackage

// File: verilog/asfr_regfile.sv
`timescale 1ns/100ps
`default_nettype none
// How it works
// - Eight 64-bit packed registers share storage with the floating-point stack.
// - Any packed register reference that does not fault sets all tag valid bits.
// - Empty-state instruction clears all tag valid bits.
// - Push onto a valid slot raises stack overflow.
// - Misaligned wide access faults unless it is the unaligned-move instruction.
// - Misaligned narrow access completes, flagged as a line split.
// - Packed-to-float switch stalls the float instruction a bounded time.
module asfr_regfile
  import asfr_pkg::*;
#(
  parameter int unsigned SWITCH_CYC = ASFR_SWITCH_CYC
) (
  // Clock and reset
  input  wire logic                   ref_clk,
  input  wire logic                   rst_b,
  // Request from pipeline
  input  wire asfr_op_t               op,
  input  wire logic [ASFR_IDX_W-1:0]  reg_idx,
  input  wire logic [ASFR_FP_W-1:0]   wr_data,
  input  wire asfr_mem_t              mem_kind,
  input  wire logic [ASFR_ADDR_W-1:0] mem_addr,
  // Answer
  output logic                        busy,
  output logic                        done,
  output logic [ASFR_FP_W-1:0]        rd_data,
  output logic [ASFR_NREGS-1:0]       tag_valid,
  output logic [ASFR_IDX_W-1:0]       stack_top,
  output logic                        ovf_exc,
  output logic                        align_exc,
  output logic                        line_split
);
  // ==========================================================
  // State
  typedef enum logic [1:0] {
    ASFR_ST_PK,
    ASFR_ST_FP
  } asfr_mode_t;

  logic [ASFR_FP_W-1:0]  regs_q [ASFR_NREGS];
  logic [ASFR_FP_W-1:0]  regs_d [ASFR_NREGS];
  logic [ASFR_NREGS-1:0] tag_q, tag_d;
  logic [ASFR_IDX_W-1:0] top_q, top_d;
  asfr_mode_t            mode_q, mode_d;
  logic [7:0]            wait_q, wait_d;
  logic                  busy_q, busy_d;
  logic                  done_q, done_d;
  logic [ASFR_FP_W-1:0]  rdat_q, rdat_d;
  logic                  ovf_q, ovf_d;
  logic                  alx_q, alx_d;
  logic                  spl_q, spl_d;

  asfr_align_if          al ();
  logic [ASFR_IDX_W-1:0] push_slot;
  logic                  is_fp;
  logic                  is_pk;
  logic                  run;
  logic                  fault;
  // A zero wait must not re-arm the guard on every edge
  localparam logic [7:0] WAIT_LOAD = 8'(SWITCH_CYC);

  // ==========================================================
  // Decode
  // Packed and float ops reach the same rows
  assign is_pk   = (op == ASFR_OP_PK_WR) || (op == ASFR_OP_PK_RD);
  assign is_fp   = (op == ASFR_OP_FP_PUSH) || (op == ASFR_OP_FP_WR) || (op == ASFR_OP_FP_RD);
  // Only packed references carry a checked memory operand
  assign fault   = is_pk && al.fault;
  assign al.kind = mem_kind;
  assign al.addr = mem_addr;

  asfr_align_chk u_chk (
    .m (al.chk)
  );

  // ==========================================================
  // Switch guard: float op after packed use is held off
  always_comb begin
    mode_d = mode_q;
    wait_d = 8'h00;
    busy_d = 1'b0;
    run    = 1'b0;
    // Pipeline must hold a float op while busy, else it is dropped
    if (is_fp && mode_q == ASFR_ST_PK && wait_q == 8'h00 && WAIT_LOAD != 8'h00) begin
      wait_d = WAIT_LOAD;
      busy_d = 1'b1;
    end else if (is_fp && wait_q > 8'h01) begin
      wait_d = wait_q - 8'h01;
      busy_d = 1'b1;
    end else begin
      run = (op != ASFR_OP_NONE);
      if (is_fp) begin
        mode_d = ASFR_ST_FP;
      end
      // A refused reference leaves the mode alone
      if (is_pk && !fault) begin
        mode_d = ASFR_ST_PK;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      mode_q <= ASFR_ST_FP;
      wait_q <= 8'h00;
      busy_q <= 1'b0;
    end else begin
      mode_q <= mode_d;
      wait_q <= wait_d;
      busy_q <= busy_d;
    end
  end

  // ==========================================================
  // Execute
  always_comb begin
    regs_d    = regs_q;
    tag_d     = tag_q;
    top_d     = top_q;
    done_d    = 1'b0;
    rdat_d    = rdat_q;
    ovf_d     = 1'b0;
    alx_d     = 1'b0;
    spl_d     = 1'b0;
    push_slot = top_q - 3'h1;
    if (run && fault) begin
      // Refused: only the flag and done, no state change
      alx_d  = 1'b1;
      done_d = 1'b1;
    end else if (run) begin
      spl_d = is_pk && al.split;
      case (op)
        ASFR_OP_PK_WR: begin
          // Packed write fills mantissa; exponent bits forced to ones
          regs_d[reg_idx] = {ASFR_EXP_ONES, wr_data[ASFR_PK_W-1:0]};
          tag_d           = ASFR_TAG_ALL;
          done_d          = 1'b1;
        end
        ASFR_OP_PK_RD: begin
          rdat_d = {16'h0000, regs_q[reg_idx][ASFR_PK_W-1:0]};
          tag_d  = ASFR_TAG_ALL;
          done_d = 1'b1;
        end
        ASFR_OP_EMPTY: begin
          tag_d  = ASFR_TAG_NONE;
          done_d = 1'b1;
        end
        ASFR_OP_FP_PUSH: begin
          // Slot below top; a valid slot there means the stack is full
          if (tag_q[push_slot]) begin
            ovf_d = 1'b1;
          end else begin
            regs_d[push_slot] = wr_data;
            tag_d[push_slot]  = 1'b1;
            top_d             = push_slot;
          end
          done_d = 1'b1;
        end
        // Stack-relative index wraps round the eight rows
        ASFR_OP_FP_WR: begin
          regs_d[reg_idx + top_q] = wr_data;
          done_d                  = 1'b1;
        end
        ASFR_OP_FP_RD: begin
          rdat_d = regs_q[reg_idx + top_q];
          done_d = 1'b1;
        end
        default: begin
          done_d = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      tag_q  <= ASFR_TAG_NONE;
      top_q  <= '0;
      done_q <= 1'b0;
      rdat_q <= '0;
      ovf_q  <= 1'b0;
      alx_q  <= 1'b0;
      spl_q  <= 1'b0;
    end else begin
      tag_q  <= tag_d;
      top_q  <= top_d;
      done_q <= done_d;
      rdat_q <= rdat_d;
      ovf_q  <= ovf_d;
      alx_q  <= alx_d;
      spl_q  <= spl_d;
    end
  end

  // ==========================================================
  // Shared storage: one row per physical register
  for (genvar g = 0; g < ASFR_NREGS; g++) begin : g_row
    // Each row is written through either view
    always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
        regs_q[g] <= '0;
      end else begin
        regs_q[g] <= regs_d[g];
      end
    end
  end

  // ==========================================================
  // Outputs, each straight from a flop
  assign busy       = busy_q;
  assign done       = done_q;
  assign rd_data    = rdat_q;
  assign tag_valid  = tag_q;
  assign stack_top  = top_q;
  assign ovf_exc    = ovf_q;
  assign align_exc  = alx_q;
  assign line_split = spl_q;
endmodule
`default_nettype wire
